/* rtc_cal_pkg.sv */
// Constants, field layouts and types shared by the calendar core
//
// Overview of operation
// [R1] Time register writable only in initialization mode
// [R2] Date register writable only in initialization mode
// [R3] Time holds BCD seconds, minutes, hours
// [R4] Time bit 22 flags PM half
// [R5] Date holds BCD day, month, year
// [R6] Date bits 15:13 hold weekday code
// [R7] Control bits 7,6,4 writable only in init
// [R8] Software avoids control rewrite during hour increment
// [R9] Hour adjust requests act at next second
// [R10] Bit 3 picks stamp edge, locked while enabled
// [R11] Bit 4 enables reference clock detection
// [R12] Bit 5 picks shadow or direct reads
// [R13] Software picks direct reads on slow bus
// [R14] Bit 6 picks 24-hour or AM/PM counting
// [R15] Bits 8, 12 enable alarm and interrupt
// [R16] Bits 11, 15 enable stamp and interrupt
// [R17] Bit 16 reads zero, adds one hour
// [R18] Bit 17 reads zero, subtracts hour unless zero
// [R19] Bit 18 is plain daylight-saving memo bit
// [R20] Bit 19 selects 512 Hz or 1 Hz output
// [R21] Bit 20 sets alarm pin level polarity
// [R22] Bits 22:21 select alarm output source
// [R23] Bit 23 enables calibration clock output
// [R24] Reserved bits read zero, ignore writes
package rtc_cal_pkg;

    // Register byte offsets
    localparam logic [3:0]  TIME_OFS       = 4'h0;
    localparam logic [3:0]  DATE_OFS       = 4'h4;
    localparam logic [3:0]  CTRL_OFS       = 4'h8;

    // Values after reset
    localparam logic [31:0] TIME_RST       = 32'h0000_0000;
    localparam logic [31:0] DATE_RST       = 32'h0000_2101;
    localparam logic [31:0] CTRL_RST       = 32'h0000_0000;

    // Implemented bits of each register
    localparam logic [31:0] TIME_MASK      = 32'h007f_7f7f;
    localparam logic [31:0] DATE_MASK      = 32'h00ff_ff3f;
    localparam logic [31:0] CTRL_MASK      = 32'h00fc_9978;
    localparam logic [31:0] CTRL_INIT_ONLY = 32'h0000_00d0;

    // Control field positions and the time PM flag
    localparam int          CTRL_TS_EDGE   = 3;
    localparam int          CTRL_REF_DET   = 4;
    localparam int          CTRL_DIRECT    = 5;
    localparam int          CTRL_HOUR_FMT  = 6;
    localparam int          CTRL_ALARM_ON  = 8;
    localparam int          CTRL_STAMP_ON  = 11;
    localparam int          CTRL_ALARM_IRQ = 12;
    localparam int          CTRL_STAMP_IRQ = 15;
    localparam int          CTRL_ADD_HR    = 16;
    localparam int          CTRL_SUB_HR    = 17;
    localparam int          CTRL_DST_MEMO  = 18;
    localparam int          CTRL_CAL_RATE  = 19;
    localparam int          CTRL_POLARITY  = 20;
    localparam int          CTRL_SRC_LO    = 21;
    localparam int          CTRL_CAL_ON    = 23;
    localparam int          TIME_PM        = 22;

    // Prescaler defaults and the divider tap for the fast calibration rate
    localparam logic [6:0]  ASYNC_PRESC_DEF = 7'h7f;
    localparam logic [14:0] SYNC_PRESC_DEF  = 15'h00ff;
    localparam int          CAL_FAST_TAP    = 5;

    // Alarm output source codes
    typedef enum logic [1:0] {
        SRC_OFF     = 2'b00,
        SRC_ALARM_A = 2'b01,
        SRC_RSV_2   = 2'b10,
        SRC_RSV_3   = 2'b11
    } alarm_src_t;

endpackage : rtc_cal_pkg

/* rtc_calendar.sv */
// Calendar time, date and control registers behind a classic Wishbone slave
`timescale 1ns/100ps
module rtc_calendar
    import rtc_cal_pkg::*;
#(
    parameter logic [6:0]  ASYNC_PRESC = ASYNC_PRESC_DEF,
    parameter logic [14:0] SYNC_PRESC  = SYNC_PRESC_DEF
) (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Companion blocks
    input  wire logic        calendar_clock,
    input  wire logic        init_mode,
    input  wire logic        write_unlocked,
    input  wire logic        alarm_a_match_flag,
    // Control and calendar state for the rest of the clock
    output logic [31:0]      time_now,
    output logic [31:0]      date_now,
    output logic             stamp_edge_select,
    output logic             stamp_function_on,
    output logic             stamp_irq_on,
    output logic             alarm_a_on,
    output logic             alarm_a_irq_on,
    output logic             ref_clock_detect_on,
    output logic             dst_memo_bit,
    output logic             second_pulse,
    // Alarm / calibration pin
    output logic             cal_clock_output,
    output logic             cal_clock_output_oe
);

    logic [31:0] time_reg;          // Counting time register
    logic [31:0] date_reg;          // Counting date register
    logic [31:0] ctrl_reg;          // Control register
    logic [31:0] shadow_time;       // Bus-side copy of time
    logic [31:0] shadow_date;       // Bus-side copy of date
    logic        add_pending;       // Summer-time hour pending
    logic        sub_pending;       // Winter-time hour pending
    logic        cal_clock_q;       // Previous calendar clock level
    logic        shadow_phase;      // Alternates on calendar edges
    logic [6:0]  async_cnt;         // Fast prescaler stage
    logic [14:0] sync_cnt;          // Slow prescaler stage
    logic [31:0] wmask;             // Byte lanes expanded to bits
    logic        cal_edge;          // Rising calendar clock edge
    logic        sec_tick;          // One-second boundary
    logic        wr_go;             // Bus write taken this cycle
    logic        rd_go;             // Bus read taken this cycle
    logic        cal_wr;            // Calendar write allowed
    logic [31:0] next_time;         // Time after the second
    logic [31:0] next_date;         // Date after a day roll
    logic [31:0] ctrl_wmask;        // Writable control bits now
    logic        day_carry;         // Midnight crossed

    // Byte enables widened to a per-bit write mask
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign wmask[8*b +: 8] = {8{sel_i[b]}};
    end

    assign wr_go    = cyc_i & stb_i & we_i & ~ack_o;
    assign rd_go    = cyc_i & stb_i & ~we_i & ~ack_o;
    assign cal_wr   = wr_go & init_mode & write_unlocked;
    assign cal_edge = calendar_clock & ~cal_clock_q;
    assign sec_tick = cal_edge & ~init_mode & (async_cnt == ASYNC_PRESC)
                      & (sync_cnt == SYNC_PRESC);

    // Register-backed outputs
    assign time_now            = time_reg;
    assign date_now            = date_reg;
    assign stamp_edge_select   = ctrl_reg[CTRL_TS_EDGE];
    assign stamp_function_on   = ctrl_reg[CTRL_STAMP_ON];
    assign stamp_irq_on        = ctrl_reg[CTRL_STAMP_IRQ];      // [R16]
    assign alarm_a_on          = ctrl_reg[CTRL_ALARM_ON];
    assign alarm_a_irq_on      = ctrl_reg[CTRL_ALARM_IRQ];      // [R15]
    assign ref_clock_detect_on = ctrl_reg[CTRL_REF_DET];        // [R11]
    assign dst_memo_bit        = ctrl_reg[CTRL_DST_MEMO];       // [R19]

    // Hour forward: returns {carry, pm, hour}
    function automatic logic [7:0] hour_up(input logic [5:0] h, input logic fmt,
                                           input logic pm);
        logic [7:0] r;
        r = {1'b0, pm, h};
        if (!fmt && h == 6'h23) begin
            r = {1'b1, 1'b0, 6'h00};
        end else if (fmt && h == 6'h12) begin
            r = {1'b0, pm, 6'h01};
        end else if (fmt && h == 6'h11) begin
            r = {pm, ~pm, 6'h12};                              // [R4]
        end else if (h[3:0] == 4'h9) begin
            r = {1'b0, pm, h[5:4] + 2'h1, 4'h0};
        end else begin
            r = {1'b0, pm, h[5:4], h[3:0] + 4'h1};
        end
        return r;
    endfunction : hour_up

    // Hour backward, never called with a zero hour: returns {pm, hour}
    function automatic logic [6:0] hour_down(input logic [5:0] h, input logic fmt,
                                             input logic pm);
        logic [6:0] r;
        if (fmt && h == 6'h01) begin
            r = {pm, 6'h12};
        end else if (fmt && h == 6'h12) begin
            r = {~pm, 6'h11};
        end else if (h[3:0] == 4'h0) begin
            r = {pm, h[5:4] - 2'h1, 4'h9};
        end else begin
            r = {pm, h[5:4], h[3:0] - 4'h1};
        end
        return r;
    endfunction : hour_down

    // Last day of the month in BCD, leap years every fourth year
    function automatic logic [5:0] month_end(input logic [4:0] mon,
                                             input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            5'h02:   month_end = leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: month_end = 6'h30;
            default: month_end = 6'h31;
        endcase
    endfunction : month_end

    // Next time: second carry ripple, then pending hour adjustments
    always_comb begin
        logic [7:0] up;
        logic [6:0] dn;
        logic       carry;
        next_time = time_reg;
        carry     = 1'b0;
        up        = 8'h00;
        dn        = 7'h00;
        if (time_reg[3:0] != 4'h9) begin                         // [R3]
            next_time[3:0] = time_reg[3:0] + 4'h1;
        end else begin
            next_time[3:0] = 4'h0;
            if (time_reg[6:4] != 3'h5) begin
                next_time[6:4] = time_reg[6:4] + 3'h1;
            end else begin
                next_time[6:4] = 3'h0;
                if (time_reg[11:8] != 4'h9) begin
                    next_time[11:8] = time_reg[11:8] + 4'h1;
                end else begin
                    next_time[11:8] = 4'h0;
                    if (time_reg[14:12] != 3'h5) begin
                        next_time[14:12] = time_reg[14:12] + 3'h1;
                    end else begin
                        // Hour step rolls the date at midnight
                        next_time[14:12] = 3'h0;
                        up = hour_up(time_reg[21:16], ctrl_reg[CTRL_HOUR_FMT],
                                     time_reg[TIME_PM]);               // [R14]
                        next_time[22:16] = up[6:0];
                        carry = up[7];
                    end
                end
            end
        end
        // Requests taken from the bus wait for this boundary
        if (add_pending) begin                                    // [R9] [R17]
            up = hour_up(next_time[21:16], ctrl_reg[CTRL_HOUR_FMT],
                         next_time[TIME_PM]);
            next_time[22:16] = up[6:0];
            carry = carry | up[7];
        end else if (sub_pending && next_time[21:16] != 6'h00) begin  // [R18]
            dn = hour_down(next_time[21:16], ctrl_reg[CTRL_HOUR_FMT],
                           next_time[TIME_PM]);
            next_time[22:16] = dn;
        end
        day_carry = carry;
    end

    // Next date after a day roll, weekday follows when enabled
    always_comb begin
        next_date = date_reg;
        if (date_reg[5:0] == month_end(date_reg[12:8], date_reg[23:16])) begin
            next_date[5:0] = 6'h01;
            if (date_reg[12:8] == 5'h12) begin
                next_date[12:8] = 5'h01;
                if (date_reg[19:16] != 4'h9) begin
                    next_date[19:16] = date_reg[19:16] + 4'h1;
                end else begin
                    next_date[19:16] = 4'h0;
                    next_date[23:20] = (date_reg[23:20] == 4'h9) ? 4'h0 : date_reg[23:20] + 4'h1;
                end
            end else if (date_reg[11:8] == 4'h9) begin
                next_date[12:8] = 5'h10;
            end else begin
                next_date[11:8] = date_reg[11:8] + 4'h1;
            end
        end else if (date_reg[3:0] == 4'h9) begin                // [R5]
            next_date[5:0] = {date_reg[5:4] + 2'h1, 4'h0};
        end else begin
            next_date[3:0] = date_reg[3:0] + 4'h1;
        end
        // Code 0 keeps the weekday off; Sunday wraps to Monday
        if (date_reg[15:13] == 3'h7) begin                       // [R6]
            next_date[15:13] = 3'h1;
        end else if (date_reg[15:13] != 3'h0) begin
            next_date[15:13] = date_reg[15:13] + 3'h1;
        end
    end

    // Control bits that this write may change
    always_comb begin
        ctrl_wmask = wmask & CTRL_MASK;                           // [R24]
        if (!init_mode) begin
            ctrl_wmask = ctrl_wmask & ~CTRL_INIT_ONLY;            // [R7]
        end
        if (ctrl_reg[CTRL_STAMP_ON]) begin
            ctrl_wmask[CTRL_TS_EDGE] = 1'b0;                      // [R10]
        end
    end

    // Calendar clock edge and prescaler chain; stopped in init mode
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cal_clock_q <= 1'b0;
            async_cnt   <= 7'h00;
            sync_cnt    <= 15'h0000;
        end else begin
            cal_clock_q <= calendar_clock;
            if (init_mode) begin
                async_cnt <= 7'h00;
                sync_cnt  <= 15'h0000;
            end else if (cal_edge) begin
                if (async_cnt == ASYNC_PRESC) begin
                    async_cnt <= 7'h00;
                    sync_cnt  <= (sync_cnt == SYNC_PRESC) ? 15'h0000
                                                          : sync_cnt + 15'h0001;
                end else begin
                    async_cnt <= async_cnt + 7'h01;
                end
            end
        end
    end

    // Time register: bus load in init mode, else counting
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            time_reg <= TIME_RST;
        end else if (cal_wr && adr_i == TIME_OFS) begin           // [R1]
            time_reg <= ((time_reg & ~wmask) | (dat_i & wmask)) & TIME_MASK;
        end else if (sec_tick) begin
            time_reg <= next_time;
        end
    end

    // Date register: bus load in init mode, else rolls at midnight
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            date_reg <= DATE_RST;
        end else if (cal_wr && adr_i == DATE_OFS) begin           // [R2]
            date_reg <= ((date_reg & ~wmask) | (dat_i & wmask)) & DATE_MASK;
        end else if (sec_tick && day_carry) begin
            date_reg <= next_date;
        end
    end

    // Control register; adjust request bits never stored
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_go && write_unlocked && adr_i == CTRL_OFS) begin
            ctrl_reg <= (ctrl_reg & ~ctrl_wmask) | (dat_i & ctrl_wmask);
        end
    end

    // Hour adjust requests; a new request beats the clearing tick
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            add_pending <= 1'b0;
            sub_pending <= 1'b0;
        end else begin
            if (wr_go && write_unlocked && !init_mode && adr_i == CTRL_OFS
                && sel_i[2]) begin
                add_pending <= dat_i[CTRL_ADD_HR] | (add_pending & ~sec_tick);
                sub_pending <= dat_i[CTRL_SUB_HR] | (sub_pending & ~sec_tick);
            end else if (sec_tick) begin
                add_pending <= 1'b0;
                sub_pending <= 1'b0;
            end
        end
    end

    // Shadow copies refresh on every second calendar edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            shadow_phase <= 1'b0;
            shadow_time  <= TIME_RST;
            shadow_date  <= DATE_RST;
        end else if (cal_edge) begin
            shadow_phase <= ~shadow_phase;
            if (shadow_phase) begin                               // [R12]
                shadow_time <= time_reg;
                shadow_date <= date_reg;
            end
        end
    end

    // Bus answer one cycle after the request; unmapped reads give zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            if (rd_go) begin
                case (adr_i)
                    TIME_OFS: dat_o <= ctrl_reg[CTRL_DIRECT] ? time_reg
                                                             : shadow_time;
                    DATE_OFS: dat_o <= ctrl_reg[CTRL_DIRECT] ? date_reg
                                                             : shadow_date;
                    CTRL_OFS: dat_o <= ctrl_reg & CTRL_MASK;      // [R17] [R18]
                    default:  dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Pin drive: calibration clock wins over the alarm level
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cal_clock_output    <= 1'b0;
            cal_clock_output_oe <= 1'b0;
            second_pulse        <= 1'b0;
        end else begin
            second_pulse <= sec_tick;
            if (ctrl_reg[CTRL_CAL_ON]) begin                      // [R23]
                // Rates are exact only with default prescalers
                cal_clock_output    <= ctrl_reg[CTRL_CAL_RATE]
                                       ? (sync_cnt > (SYNC_PRESC >> 1))
                                       : async_cnt[CAL_FAST_TAP];  // [R20]
                cal_clock_output_oe <= 1'b1;
            end else if (ctrl_reg[CTRL_SRC_LO +: 2] == SRC_ALARM_A) begin  // [R22]
                cal_clock_output    <= alarm_a_match_flag ^ ctrl_reg[CTRL_POLARITY];  // [R21]
                cal_clock_output_oe <= 1'b1;
            end else begin
                cal_clock_output    <= 1'b0;
                cal_clock_output_oe <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    time_write_lock_a: assert property (       // [R1]
        (wr_go && adr_i == TIME_OFS && !init_mode && !sec_tick) |=> $stable(time_reg))
        else $error("time changed by a write outside init mode");

    date_write_lock_a: assert property (       // [R2]
        (wr_go && adr_i == DATE_OFS && !init_mode && !sec_tick) |=> $stable(date_reg))
        else $error("date changed by a write outside init mode");

    second_step_a: assert property (           // [R3]
        (sec_tick && time_reg[3:0] < 4'h9)
        |=> time_reg[3:0] == $past(time_reg[3:0]) + 4'h1)
        else $error("second units did not step by one");

    init_bits_lock_a: assert property (        // [R7]
        (!init_mode) |=> $stable(ctrl_reg[CTRL_HOUR_FMT]) && $stable(ctrl_reg[CTRL_REF_DET]))
        else $error("init-only control bit changed outside init mode");

    hour_hold_a: assert property (             // [R9]
        (add_pending && !sec_tick && !cal_wr) |=> $stable(time_reg[22:16]))
        else $error("hour moved before the second boundary");

    edge_lock_a: assert property (             // [R10]
        ctrl_reg[CTRL_STAMP_ON] |=> $stable(ctrl_reg[CTRL_TS_EDGE]))
        else $error("stamp edge changed while stamping enabled");

    shadow_copy_a: assert property (           // [R12]
        (cal_edge && shadow_phase) |=> shadow_time == $past(time_reg))
        else $error("shadow time not refreshed");

    adjust_reads_zero_a: assert property (     // [R17]
        (ack_o && !we_i && adr_i == CTRL_OFS) |-> dat_o[17:16] == 2'b00)
        else $error("hour adjust bits read nonzero");

    zero_hour_keep_a: assert property (        // [R18]
        (sub_pending && !add_pending && sec_tick && time_reg[21:16] == 6'h00
         && time_reg[14:0] != 15'h5959) |=> time_reg[21:16] == 6'h00)
        else $error("winter adjust applied at hour zero");

    alarm_level_a: assert property (           // [R21]
        (!ctrl_reg[CTRL_CAL_ON] && ctrl_reg[22:21] == 2'b01)
        |=> cal_clock_output == ($past(alarm_a_match_flag) ^ $past(ctrl_reg[CTRL_POLARITY])))
        else $error("alarm pin level wrong");

    reserved_zero_a: assert property (         // [R24]
        ((time_reg & ~TIME_MASK) == 32'h0) && ((date_reg & ~DATE_MASK) == 32'h0))
        else $error("reserved calendar bit set");

endmodule : rtc_calendar

/* calendar_time_date_control_tb_top.sv */
// Self-checking bench for the calendar time, date and control registers
`timescale 1ns/100ps
module calendar_time_date_control_tb_top;
    import rtc_cal_pkg::*;
    logic        sys_clk, srst, cyc_i, stb_i, we_i;  // Clock, reset, bus strobes
    logic        init_mode, write_unlocked, alarm_flag; // Companion block levels
    logic [3:0]  adr_i, sel_i;                        // Bus address and lanes
    logic [31:0] dat_i, dat_o, time_now, date_now, rd; // Bus data, live state
    logic        ack_o, stamp_on, alarm_on, ref_on, second_pulse, pin, pin_oe;
    logic        ts_edge, stamp_irq, alarm_irq, memo_bit; // Remaining control outputs
    logic [2:0]  cal_div = 3'h0;                      // Slow calendar clock divider
    int          errors = 0;                          // Mismatches seen
    int          comparisons = 0;                     // Checks made

    // Short prescalers: one second is 16 calendar edges, 128 system cycles
    rtc_calendar #(.ASYNC_PRESC(7'h03), .SYNC_PRESC(15'h0003)) dut (
        .sys_clk(sys_clk), .srst(srst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .calendar_clock(cal_div[2]), .init_mode(init_mode),
        .write_unlocked(write_unlocked), .alarm_a_match_flag(alarm_flag),
        .time_now(time_now), .date_now(date_now), .stamp_edge_select(ts_edge),
        .stamp_function_on(stamp_on), .stamp_irq_on(stamp_irq), .alarm_a_on(alarm_on),
        .alarm_a_irq_on(alarm_irq), .ref_clock_detect_on(ref_on), .dst_memo_bit(memo_bit),
        .second_pulse(second_pulse), .cal_clock_output(pin), .cal_clock_output_oe(pin_oe));

    // System clock, 40 ns period
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Calendar clock at an eighth of the system rate: shadow reads need 7x
    always @(posedge sys_clk) begin
        cal_div <= cal_div + 3'h1;
    end

    // Compare and count; an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge sys_clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= we;
        adr_i <= adr;
        dat_i <= dat;
        sel_i <= 4'hf;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        chk({31'h0, ack_o}, 32'h1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    // Read and compare in one call
    task automatic rdchk(input logic [3:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // Set init mode and protection levels just after an edge
    task automatic mode(input logic init, input logic unl);
        @(posedge sys_clk);
        init_mode      <= init;
        write_unlocked <= unl;
    endtask : mode

    // Wait for the next second boundary, bounded
    task automatic wait_tick();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (second_pulse !== 1'b1 && n < 300);
        chk({31'h0, second_pulse}, 32'h1);
        repeat (2) @(posedge sys_clk);
    endtask : wait_tick

    // Reset values and an unmapped place
    task automatic t_reset();
        rdchk(DATE_OFS, DATE_RST);
        rdchk(CTRL_OFS, CTRL_RST);
        rdchk(4'hc, 32'h0);
        bus(1'b0, TIME_OFS, 32'h0);
        chk(rd & 32'h007f_0000, 32'h0);
    endtask : t_reset

    // Time and date writes refused outside init, date writes refused while locked
    task automatic t_time_date();
        mode(1'b0, 1'b1);
        bus(1'b1, DATE_OFS, 32'hff99_f2f1);
        rdchk(DATE_OFS, DATE_RST);
        bus(1'b1, TIME_OFS, 32'h0023_0000);
        bus(1'b0, TIME_OFS, 32'h0);
        chk(rd & 32'h007f_0000, 32'h0);
        mode(1'b1, 1'b0);
        bus(1'b1, DATE_OFS, 32'hff99_f2f1);
        rdchk(DATE_OFS, DATE_RST);
        mode(1'b1, 1'b1);
        bus(1'b1, TIME_OFS, 32'hff92_b4d6);
        bus(1'b1, DATE_OFS, 32'hff99_f2f1);
        // Shadow copy refreshes every two calendar edges, sixteen cycles here
        repeat (16) @(posedge sys_clk);
        rdchk(TIME_OFS, 32'h0012_3456);
        rdchk(DATE_OFS, 32'h0099_f231);
    endtask : t_time_date

    // Control access, init-only bits, stamp edge lock and the output pin
    task automatic t_ctrl();
        mode(1'b1, 1'b1);
        bus(1'b1, CTRL_OFS, 32'hffff_ffff);
        rdchk(CTRL_OFS, CTRL_MASK & ~32'h0003_0000);
        chk({28'h0, stamp_on, alarm_on, ref_on, pin_oe}, 32'hf);
        chk({28'h0, ts_edge, stamp_irq, alarm_irq, memo_bit}, 32'hf);
        bus(1'b1, TIME_OFS, 32'h0001_0203);
        rdchk(TIME_OFS, 32'h0001_0203);
        mode(1'b0, 1'b1);
        bus(1'b1, CTRL_OFS, 32'h0);
        rdchk(CTRL_OFS, 32'h0000_0058);
        mode(1'b0, 1'b0);
        bus(1'b1, CTRL_OFS, 32'h0004_0000);
        rdchk(CTRL_OFS, 32'h0000_0058);
        mode(1'b1, 1'b1);
        bus(1'b1, CTRL_OFS, 32'h0);
        bus(1'b1, CTRL_OFS, 32'h0);
        rdchk(CTRL_OFS, 32'h0);
        alarm_flag <= 1'b1;
        bus(1'b1, CTRL_OFS, 32'h0020_0000);
        repeat (2) @(posedge sys_clk);
        chk({30'h0, pin_oe, pin}, 32'h3);
        bus(1'b1, CTRL_OFS, 32'h0030_0000);
        repeat (2) @(posedge sys_clk);
        chk({30'h0, pin_oe, pin}, 32'h2);
        bus(1'b1, CTRL_OFS, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, pin_oe}, 32'h0);
    endtask : t_ctrl

    // Start time in init, then sync to a boundary; control writes stay clear of hour steps
    task automatic start_at(input logic [31:0] t);
        mode(1'b1, 1'b1);
        bus(1'b1, TIME_OFS, t);
        mode(1'b0, 1'b1);
        wait_tick();
    endtask : start_at

    // Hour adjust requests wait for the next second
    task automatic t_adjust();
        mode(1'b1, 1'b1);
        bus(1'b1, CTRL_OFS, 32'h0000_0040);
        start_at(32'h0011_5959);
        chk({25'h0, time_now[22:16]}, 32'h52);
        mode(1'b1, 1'b1);
        bus(1'b1, CTRL_OFS, 32'h0);
        start_at(32'h0023_5959);
        chk(date_now, 32'h0000_2101);
        start_at(32'h0010_0000);
        bus(1'b1, CTRL_OFS, 32'h0001_0000);
        chk({25'h0, time_now[22:16]}, 32'h10);
        wait_tick();
        chk({25'h0, time_now[22:16]}, 32'h11);
        bus(1'b1, CTRL_OFS, 32'h0002_0000);
        wait_tick();
        chk({25'h0, time_now[22:16]}, 32'h10);
        start_at(32'h0);
        bus(1'b1, CTRL_OFS, 32'h0002_0000);
        wait_tick();
        chk({25'h0, time_now[22:16]}, 32'h0);
    endtask : t_adjust

    // Verdict and end of run, shared with the watchdog
    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        {srst, cyc_i, stb_i, we_i, alarm_flag, init_mode, write_unlocked} = 7'b1000000;
        adr_i = 4'h0;
        sel_i = 4'h0;
        dat_i = 32'h0;
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
        t_time_date();
        t_ctrl();
        t_adjust();
        tally_and_finish();
    end

    // Watchdog: the tests need under two thousand cycles
    initial begin
        #(40 * 5000);
        errors++;
        tally_and_finish();
    end
endmodule : calendar_time_date_control_tb_top
